// *** acb_pkg.sv ***
// acb_pkg: constants and types shared by the asynchronous cpu bus interface
// assumes a single 100 MHz clock domain and synchronous pin inputs
`default_nettype none
package acb_pkg;
  localparam int ADDR_W = 24;                     // address bus width
  localparam int DATA_W = 16;                     // data bus width
  localparam int LVL_W = 3;                       // interrupt level width
  localparam int FC_W = 3;                        // space code width
  localparam logic [2:0] LVL_NMI = 3'h7;          // top level, never masked
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;    // autovector base number
  localparam logic [ADDR_W-1:0] IACK_ADDR = 24'hffffff; // idle-high iack address
  localparam logic [FC_W-1:0] FC_IACK = 3'h7;     // cpu space code
  localparam logic [FC_W-1:0] FC_NONE = 3'h0;     // space code at reset
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000; // address reset value
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;   // data reset value
  // bus cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_STRB = 3'b010,
    ST_WAIT = 3'b011,
    ST_END = 3'b100,
    ST_GRANT = 3'b101
  } acb_state_type;
  // kind of request from the core
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_IACK = 2'b10
  } acb_op_type;
endpackage
`default_nettype wire

// *** acb_irq_level.sv ***
// acb_irq_level: registers the encoded interrupt level and decides pendency
// assumes level inputs are synchronous to clk
`default_nettype none
module acb_irq_level
  import acb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [acb_pkg::LVL_W-1:0] irqLevelIn,
  input wire logic [acb_pkg::LVL_W-1:0] irqMask,
  output logic [acb_pkg::LVL_W-1:0] pendLevel,
  output logic irqPending
);
  logic [LVL_W-1:0] lvl_q, lvl_d; // latched level
  logic pend_q, pend_d;           // pending flag

  // next level and pending decision
  always_comb begin
    lvl_d = lvl_q;
    pend_d = pend_q;
    if (clkEn) begin
      lvl_d = irqLevelIn;
      pend_d = (irqLevelIn == LVL_NMI) || (irqLevelIn > irqMask);
    end
  end

  // state registers, held when the clock enable is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_q <= '0;
      pend_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      pend_q <= pend_d;
    end
  end

  assign pendLevel = lvl_q;
  assign irqPending = pend_q;
endmodule
`default_nettype wire

// *** acb_bus_if.sv ***
// acb_bus_if: external asynchronous bus master of a small static processor
// assumes all pin inputs are synchronous to clk; pads resolve tri-states
// Functional notes
// - 24-bit address out, except iack cycles
// - iack: level on A3-A1, rest high
// - static width strap picks 8 or 16
// - address strobe only with valid address
// - direction output marks read or write
// - upper and lower data strobes
// - cycle unfinished until acknowledge arrives
// - grant, release after current cycle
// - three encoded interrupt level inputs
// - level 7 highest, never masked
// - autovector generates vector from level
// - reset and halt inputs stop operation
// - bus fault ends current cycle erroneously
// - low power keeps sequencer state; interrupt level capture keeps running
// - static: clock stop loses nothing
// - space code valid with address strobe
`default_nettype none
module acb_bus_if
  import acb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic lowPower,
  input wire logic halt_n,
  input wire logic byteMode,
  input wire logic reqValid,
  input wire acb_pkg::acb_op_type reqOp,
  input wire logic [acb_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [1:0] reqSize,
  input wire logic [acb_pkg::DATA_W-1:0] reqWdata,
  input wire logic [acb_pkg::FC_W-1:0] reqSpace,
  input wire logic [acb_pkg::LVL_W-1:0] irqMask,
  output logic reqReady,
  output logic respValid,
  output logic respFault,
  output logic [acb_pkg::DATA_W-1:0] respRdata,
  output logic irqPendingOut,
  output logic [acb_pkg::LVL_W-1:0] irqLevelOut,
  output logic [acb_pkg::ADDR_W-1:0] addr_out,
  output logic addrOe,
  output logic [acb_pkg::DATA_W-1:0] dataOut,
  input wire logic [acb_pkg::DATA_W-1:0] dataIn,
  output logic dataOe,
  output logic addr_strobe_n,
  output logic readNotWrite,
  output logic upper_byte_strobe_n,
  output logic lower_byte_strobe_n,
  output logic [acb_pkg::FC_W-1:0] space_code_out,
  input wire logic transfer_ack_n,
  input wire logic bus_fault_n,
  input wire logic bus_req_n,
  output logic bus_grant_n,
  input wire logic [acb_pkg::LVL_W-1:0] irq_level_in,
  input wire logic auto_vector_n
);
  acb_state_type st_q, st_d;                 // sequencer state
  logic [ADDR_W-1:0] addr_q, addr_d;         // address pins
  logic aoe_q, aoe_d;                        // address/control drive enable
  logic [DATA_W-1:0] dout_q, dout_d;         // write data pins
  logic doe_q, doe_d;                        // data drive enable
  logic as_n_q, as_n_d;                      // address strobe
  logic rnw_q, rnw_d;                        // direction
  logic uds_n_q, uds_n_d, lds_n_q, lds_n_d;  // data strobes
  logic [FC_W-1:0] fc_q, fc_d;               // space code
  logic bg_n_q, bg_n_d;                      // grant
  logic rdy_q, rdy_d;                        // request accept
  logic rv_q, rv_d, rf_q, rf_d;              // response valid and fault
  logic [DATA_W-1:0] rdat_q, rdat_d;         // response data
  logic [DATA_W-1:0] wdat_q, wdat_d;         // saved write data
  logic [1:0] size_q, size_d;                // saved size: 1 byte, 2 word
  logic byteHi_q, byteHi_d;                  // high byte of a split word, second byte still to come
  acb_op_type op_q, op_d;                    // saved operation
  logic [LVL_W-1:0] pendLevel;               // registered level
  logic irqPending;                          // level 7 or above mask
  logic run;                                 // sequencer may advance

  // interrupt level capture and masking
  acb_irq_level uLevel (
    .clk(clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .irqLevelIn(irq_level_in),
    .irqMask(irqMask),
    .pendLevel(pendLevel),
    .irqPending(irqPending)
  );

  // freeze the sequencer when halted, in low power or with the clock enable low; state is kept
  assign run = clkEn && halt_n && !lowPower;

  // bus cycle sequencer next state
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    aoe_d = aoe_q;
    dout_d = dout_q;
    doe_d = doe_q;
    as_n_d = as_n_q;
    rnw_d = rnw_q;
    uds_n_d = uds_n_q;
    lds_n_d = lds_n_q;
    fc_d = fc_q;
    bg_n_d = bg_n_q;
    rdy_d = 1'b0;
    rv_d = 1'b0;
    rf_d = rf_q;
    rdat_d = rdat_q;
    wdat_d = wdat_q;
    size_d = size_q;
    byteHi_d = byteHi_q;
    op_d = op_q;
    if (run) begin
      unique case (st_q)
        ST_IDLE: begin
          if (!bus_req_n) begin
            bg_n_d = 1'b0;
            aoe_d = 1'b0;
            st_d = ST_GRANT;
          end else if (reqValid) begin
            rdy_d = 1'b1;
            op_d = reqOp;
            wdat_d = reqWdata;
            size_d = reqSize;
            byteHi_d = byteMode && (reqSize == 2'h2) && (reqOp != OP_IACK);
            aoe_d = 1'b1;
            rnw_d = (reqOp != OP_WRITE);
            if (reqOp == OP_IACK) begin
              addr_d = IACK_ADDR;
              addr_d[3:1] = pendLevel;
              fc_d = FC_IACK;
            end else begin
              addr_d = reqAddr;
              fc_d = reqSpace;
              if (byteMode && reqSize == 2'h2) begin
                addr_d[0] = 1'b0;                         // high byte first
              end
            end
            st_d = ST_ADDR;
          end
        end
        ST_ADDR: begin
          as_n_d = 1'b0;
          if (op_q == OP_WRITE) begin
            doe_d = 1'b1;
            dout_d = byteMode ? {8'h00, (byteHi_q ? wdat_q[15:8] : wdat_q[7:0])}
                              : wdat_q;
          end
          st_d = ST_STRB;
        end
        ST_STRB: begin
          if (byteMode || op_q == OP_IACK) begin        // strap or an iack cycle picks the lanes
            lds_n_d = 1'b0;
            uds_n_d = 1'b1;
          end else if (size_q == 2'h2) begin
            uds_n_d = 1'b0;
            lds_n_d = 1'b0;
          end else begin
            uds_n_d = addr_q[0];
            lds_n_d = !addr_q[0];
          end
          st_d = ST_WAIT;
        end
        ST_WAIT: begin
          // hold all outputs until the far end answers
          if (!bus_fault_n) begin
            rf_d = 1'b1;
            byteHi_d = 1'b0;
            st_d = ST_END;
          end else if (!transfer_ack_n || (op_q == OP_IACK && !auto_vector_n)) begin
            rf_d = 1'b0;
            if (op_q == OP_IACK && !auto_vector_n) begin
              rdat_d = {8'h00, AUTOVEC_BASE + {5'h00, pendLevel}};
            end else if (byteMode) begin
              if (byteHi_q) rdat_d[15:8] = dataIn[7:0];
              else if (size_q == 2'h2) rdat_d[7:0] = dataIn[7:0];
              else rdat_d = {8'h00, dataIn[7:0]};
            end else begin
              rdat_d = dataIn;
            end
            st_d = ST_END;
          end
        end
        ST_END: begin
          as_n_d = 1'b1;
          uds_n_d = 1'b1;
          lds_n_d = 1'b1;
          doe_d = 1'b0;
          if (byteHi_q) begin
            byteHi_d = 1'b0;                              // second byte
            addr_d[0] = 1'b1;
            st_d = ST_ADDR;
          end else begin
            rv_d = 1'b1;
            st_d = ST_IDLE;
          end
        end
        ST_GRANT: begin
          if (bus_req_n) begin
            bg_n_d = 1'b1;
            st_d = ST_IDLE;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // registers; async reset to constants only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      addr_q <= ADDR_RST;
      aoe_q <= 1'b0;
      dout_q <= DATA_RST;
      doe_q <= 1'b0;
      as_n_q <= 1'b1;
      rnw_q <= 1'b1;
      uds_n_q <= 1'b1;
      lds_n_q <= 1'b1;
      fc_q <= FC_NONE;
      bg_n_q <= 1'b1;
      rdy_q <= 1'b0;
      rv_q <= 1'b0;
      rf_q <= 1'b0;
      rdat_q <= DATA_RST;
      wdat_q <= DATA_RST;
      size_q <= 2'h0;
      byteHi_q <= 1'b0;
      op_q <= OP_READ;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      aoe_q <= aoe_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      as_n_q <= as_n_d;
      rnw_q <= rnw_d;
      uds_n_q <= uds_n_d;
      lds_n_q <= lds_n_d;
      fc_q <= fc_d;
      bg_n_q <= bg_n_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      rf_q <= rf_d;
      rdat_q <= rdat_d;
      wdat_q <= wdat_d;
      size_q <= size_d;
      byteHi_q <= byteHi_d;
      op_q <= op_d;
    end
  end

  // pins and core side straight from flip-flops
  assign addr_out = addr_q;
  assign addrOe = aoe_q;
  assign dataOut = dout_q;
  assign dataOe = doe_q;
  assign addr_strobe_n = as_n_q;
  assign readNotWrite = rnw_q;
  assign upper_byte_strobe_n = uds_n_q;
  assign lower_byte_strobe_n = lds_n_q;
  assign space_code_out = fc_q;
  assign bus_grant_n = bg_n_q;
  assign reqReady = rdy_q;
  assign respValid = rv_q;
  assign respFault = rf_q;
  assign respRdata = rdat_q;
  assign irqPendingOut = irqPending;
  assign irqLevelOut = pendLevel;
endmodule
`default_nettype wire

// *** acb_bus_if_chk.sv ***
// acb_bus_if_chk: pin protocol assertions for acb_bus_if
// assumes one clock domain; bound into every acb_bus_if instance
`default_nettype none
module acb_bus_if_chk
  import acb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic halt_n,
  input wire logic lowPower,
  input wire logic byteMode,
  input wire logic reqReady,
  input wire logic respValid,
  input wire logic irqPendingOut,
  input wire logic [acb_pkg::LVL_W-1:0] irqLevelOut,
  input wire logic [acb_pkg::ADDR_W-1:0] addr_out,
  input wire logic addrOe,
  input wire logic dataOe,
  input wire logic addr_strobe_n,
  input wire logic readNotWrite,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic [acb_pkg::FC_W-1:0] space_code_out,
  input wire logic transfer_ack_n,
  input wire logic bus_fault_n,
  input wire logic bus_req_n,
  input wire logic bus_grant_n,
  input wire logic [acb_pkg::LVL_W-1:0] irq_level_in,
  input wire logic auto_vector_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // sequencer advances only on these edges
  wire logic run = clkEn && halt_n && !lowPower;
  // strobe held across two edges
  sequence s_strobed;
    !addr_strobe_n ##1 !addr_strobe_n;
  endsequence
  a_addr_held: assert property (s_strobed |->
    $stable(addr_out) && $stable(readNotWrite) && $stable(space_code_out))
    else $error("cycle outputs moved under strobe");
  a_strobe_valid: assert property (!addr_strobe_n |-> addrOe)
    else $error("strobe without driven address");
  a_data_strobe: assert property (
    !(upper_byte_strobe_n && lower_byte_strobe_n) |-> !addr_strobe_n)
    else $error("data strobe outside address strobe");
  a_iack_addr: assert property (
    (!addr_strobe_n && space_code_out == FC_IACK) |-> addr_out[23:4] == 20'hfffff && addr_out[0])
    else $error("iack address wrong");
  a_done_cause: assert property (respValid |->
    $past(!transfer_ack_n || !bus_fault_n || !auto_vector_n))
    else $error("cycle ended without acknowledge");
  a_resp_min: assert property (reqReady && run |=> !respValid [*3])
    else $error("response too early");
  a_grant_quiet: assert property (!bus_grant_n |-> !addrOe && addr_strobe_n)
    else $error("bus driven while granted");
  a_grant_cause: assert property ($fell(bus_grant_n) |->
    $past(!bus_req_n) && $past(addr_strobe_n))
    else $error("grant inside a cycle");
  a_byte_lane: assert property (byteMode && !addr_strobe_n |-> upper_byte_strobe_n)
    else $error("upper lane used in byte mode");
  a_write_dir: assert property (dataOe |-> !readNotWrite)
    else $error("data driven on read");
  a_nmi_pend: assert property (run && irq_level_in == LVL_NMI |=>
    irqPendingOut && irqLevelOut == LVL_NMI)
    else $error("top level not pending");
  a_freeze_hold: assert property (!run |=>
    $stable(addr_out) && $stable(addr_strobe_n) && $stable(bus_grant_n))
    else $error("bus moved while frozen");
endmodule
bind acb_bus_if acb_bus_if_chk i_acb_bus_if_chk (.clk, .rst_b, .clkEn, .halt_n, .lowPower,
  .byteMode, .reqReady, .respValid, .irqPendingOut, .irqLevelOut, .addr_out, .addrOe, .dataOe,
  .addr_strobe_n, .readNotWrite, .upper_byte_strobe_n, .lower_byte_strobe_n, .space_code_out,
  .transfer_ack_n, .bus_fault_n, .bus_req_n, .bus_grant_n, .irq_level_in, .auto_vector_n);
`default_nettype wire

// *** acb_mem_model.sv ***
// acb_mem_model: memory and interrupt source facing acb_bus_if
// assumes the bench sets wait, fault and autovector controls between cycles
`default_nettype none
module acb_mem_model
  import acb_pkg::*;
(
  input wire logic clk,
  input wire logic byteMode,
  input wire logic [acb_pkg::ADDR_W-1:0] addr_out,
  input wire logic [acb_pkg::DATA_W-1:0] dataOut,
  input wire logic addr_strobe_n,
  input wire logic readNotWrite,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic [acb_pkg::FC_W-1:0] space_code_out,
  input wire logic [3:0] waitCycles,
  input wire logic faultEn,
  input wire logic avecEn,
  output logic [acb_pkg::DATA_W-1:0] dataIn,
  output logic transfer_ack_n,
  output logic bus_fault_n,
  output logic auto_vector_n
);
  logic [7:0] mem [int]; // byte store
  logic [3:0] cnt = 4'h0; // wait states served
  logic [15:0] lastRd = 16'h0000; // last value put on the bus
  wire logic [23:0] ev = {addr_out[23:1], 1'b0};
  wire logic busy = !addr_strobe_n && !(upper_byte_strobe_n && lower_byte_strobe_n);
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction
  initial {transfer_ack_n, bus_fault_n, auto_vector_n} = 3'h7;
  // read lanes only while strobed, otherwise the inverse of the last value
  always @* begin
    if (busy && readNotWrite)
      dataIn = byteMode ? {2{rd(addr_out)}} : {rd(ev), rd(ev + 1)};
    else
      dataIn = ~lastRd;
  end
  // answer after the wait count, hold it until the address strobe rises
  always @(posedge clk) begin
    if (busy && readNotWrite) lastRd <= dataIn;
    if (!busy) begin
      cnt <= 4'h0;
      {transfer_ack_n, bus_fault_n, auto_vector_n} <= 3'h7;
    end else if (cnt < waitCycles) begin
      cnt <= cnt + 4'h1; // slow device
    end else if (space_code_out == FC_IACK && avecEn) begin
      auto_vector_n <= 1'b0;
    end else if (faultEn) begin
      bus_fault_n <= 1'b0;
    end else begin
      transfer_ack_n <= 1'b0;
      if (!readNotWrite && byteMode) mem[addr_out] = dataOut[7:0];
      if (!readNotWrite && !byteMode && !upper_byte_strobe_n) mem[ev] = dataOut[15:8];
      if (!readNotWrite && !byteMode && !lower_byte_strobe_n) mem[ev + 1] = dataOut[7:0];
    end
  end
endmodule
`default_nettype wire

// *** test_acb_bus_if.sv ***
// test_acb_bus_if: self-checking bench for acb_bus_if with a memory model
// assumes acb_mem_model and the bound checker are compiled alongside
`default_nettype none
module test_acb_bus_if import acb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, byteMode = 0, reqValid = 0, faultEn = 0, avecEn = 0;
  logic bus_req_n = 1, reqReady, respValid, respFault, irqPendingOut, bus_grant_n;
  logic clkEn = 1, halt_n = 1, lowPower = 0; // freeze controls
  logic addr_strobe_n, readNotWrite, upper_byte_strobe_n, lower_byte_strobe_n;
  logic transfer_ack_n, bus_fault_n, auto_vector_n;
  acb_op_type reqOp = OP_READ;
  logic [23:0] reqAddr = 24'h0, addr_out, a;
  logic [15:0] reqWdata = 16'h0, respRdata, dataOut, dataIn, d;
  logic [2:0] irqMask = 3'h0, irq_level_in = 3'h0, irqLevelOut, space_code_out;
  logic [3:0] waitCycles = 4'h0;
  int seed = 98464, err_count = 0, n_tests = 0, cycles = 0;
  logic [7:0] refMem [int]; // bench copy of memory
  acb_bus_if i_acb_bus_if (.clk, .rst_b, .clkEn, .lowPower, .halt_n,
    .byteMode, .reqValid, .reqOp, .reqAddr, .reqSize(2'h2), .reqWdata, .reqSpace(3'h5),
    .irqMask, .reqReady, .respValid, .respFault, .respRdata, .irqPendingOut, .irqLevelOut,
    .addr_out, .addrOe(), .dataOut, .dataIn, .dataOe(), .addr_strobe_n, .readNotWrite,
    .upper_byte_strobe_n, .lower_byte_strobe_n, .space_code_out, .transfer_ack_n,
    .bus_fault_n, .bus_req_n, .bus_grant_n, .irq_level_in, .auto_vector_n);
  acb_mem_model i_acb_mem_model (.clk, .byteMode, .addr_out, .dataOut, .addr_strobe_n,
    .readNotWrite, .upper_byte_strobe_n, .lower_byte_strobe_n, .space_code_out, .waitCycles,
    .faultEn, .avecEn, .dataIn, .transfer_ack_n, .bus_fault_n, .auto_vector_n);
  initial forever #5 clk = ~clk;
  task stop_test;
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // stop the clock, halt or sleep the block (k picks which), or undo it
  task freeze(input int k, input logic on);
    clkEn = !(on && k == 0);
    halt_n = !(on && k == 1);
    lowPower = on && k == 2;
  endtask
  // one bus request, held until taken, then wait for its answer
  task tx(input acb_op_type op, input logic [23:0] ad, input logic [15:0] wd);
    reqOp = op; reqAddr = ad; reqWdata = wd; reqValid = 1;
    do begin @(posedge clk); #1; end while (reqReady !== 1'b1);
    reqValid = 0;
    while (respValid !== 1'b1) begin @(posedge clk); #1; end
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin err_count++; stop_test; end
  end
  initial begin
    for (int m = 0; m < 2; m++) begin
      rst_b = 0; byteMode = m[0]; // strap only changes under reset
      repeat (20) @(posedge clk);
      #1 rst_b = 1;
      for (int i = 0; i < 6; i++) begin
        a = $random(seed); a[0] = 0; d = $random(seed); waitCycles = $random(seed);
        tx(OP_WRITE, a, d);
        refMem[a] = d[15:8]; refMem[a + 1] = d[7:0];
        // freeze the block in mid-cycle for four edges, then let it finish
        fork
          tx(OP_READ, a, 16'h0);
          begin
            repeat (3) @(posedge clk);
            #1 freeze(i % 3, 1'b1);
            repeat (4) @(posedge clk);
            #1 freeze(i % 3, 1'b0);
          end
        join
        chk(respRdata, {refMem[a], refMem[a + 1]});
        chk(addr_out[15:0], {a[15:1], byteMode});
        chk(space_code_out, 3'h5);
        chk(respFault, 1'b0);
      end
      faultEn = 1; tx(OP_READ, a, 16'h0); faultEn = 0;
      chk(respFault, 1'b1);
      avecEn = 1;
      for (int l = 1; l < 8; l++) begin
        irq_level_in = l; repeat (2) @(posedge clk); #1;
        tx(OP_IACK, 24'h0, 16'h0);
        chk(respRdata[7:0], AUTOVEC_BASE + l);
        chk(addr_out[15:0], {12'hfff, l[2:0], 1'b1});
        chk(space_code_out, FC_IACK);
      end
      avecEn = 0;
      for (int i = 0; i < 8; i++) begin
        irq_level_in = $random(seed); irqMask = $random(seed); repeat (2) @(posedge clk); #1;
        chk(irqPendingOut, irq_level_in == 7 || irq_level_in > irqMask);
      end
      bus_req_n = 0; reqValid = 1;
      repeat (3) begin @(posedge clk); #1; chk(reqReady, 1'b0); end
      chk(bus_grant_n, 1'b0);
      bus_req_n = 1; tx(OP_READ, a, 16'h0);
      chk(bus_grant_n, 1'b1);
    end
    stop_test;
  end
endmodule
`default_nettype wire
